/* File: acd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acd_host_model (
  input  wire logic       ref_clk,
  input  wire logic       dout,
  output logic            cs_n,
  output logic            sclk,
  output logic            din,
  output logic            rx_stb,
  output logic      [7:0] rx_byte
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end

  // The high phase is the longer one, so dout has settled before the fall that samples it.
  task automatic xfer(input logic [7:0] tx, input logic chk);
    for (int i = 7; i >= 0; i--) begin
      cs_n <= 1'b0;
      sclk <= 1'b1;
      din <= tx[i];
      repeat (5) @(posedge ref_clk);
      sclk <= 1'b0;
      rx_byte[i] <= dout;
      repeat (3) @(posedge ref_clk);
    end
    // A line nobody drives has no meaning, so it shows the inverse of the last bit.
    din <= ~tx[0];
    rx_stb <= chk;
    @(posedge ref_clk);
    rx_stb <= 1'b0;
  endtask : xfer

  task automatic stop_frame();
    cs_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : stop_frame
endmodule : acd_host_model
`default_nettype wire

/* File: acd_pkg.sv */
`default_nettype none
package acd_pkg;
  localparam int unsigned APB_AW         = 12;
  localparam int unsigned NREG           = 9;
  localparam logic [3:0]  REG_LAST       = 4'h8;
  localparam logic [9:0]  APB_STATUS_IDX = 10'h009;

  localparam logic [7:0] REG_RST [0:NREG-1] = '{
    8'h85, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40
  };
  localparam logic [7:0] REG_WMASK [0:NREG-1] = '{
    8'h05, 8'hdf, 8'h37, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
  };

  localparam logic [3:0] CFG0_IDX       = 4'h0;
  localparam logic [3:0] CFG1_IDX       = 4'h1;
  localparam logic [3:0] CFG2_IDX       = 4'h2;
  localparam int unsigned CFG1_FLAG_BIT = 7;
  localparam int unsigned CFG1_SUM_BIT  = 6;
  localparam int unsigned CFG2_PULSE_BIT = 4;

  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_CONT_BIT  = 1;
  localparam int unsigned STAT_RUN_BIT   = 2;
  localparam int unsigned STAT_SLEEP_BIT = 3;

  localparam logic [6:0] OP7_WAKE  = 7'h01;
  localparam logic [6:0] OP7_SLEEP = 7'h02;
  localparam logic [6:0] OP7_RESET = 7'h03;
  localparam logic [6:0] OP7_START = 7'h04;
  localparam logic [6:0] OP7_STOP  = 7'h05;
  localparam logic [6:0] OP7_RDATA = 7'h09;
  localparam logic [7:0] OP_CONT   = 8'h10;
  localparam logic [7:0] OP_CANCEL = 8'h11;
  localparam logic [7:0] OP_ZERO_OFFSET_CAL_CMD = 8'h18;
  localparam logic [7:0] OP_FULL_SCALE_CAL_CMD = 8'h19;
  localparam logic [3:0] OP_REGISTER_READ_CMD_HI = 4'h2;
  localparam logic [3:0] OP_REGISTER_WRITE_CMD_HI = 4'h4;

  localparam logic [7:0] SUM_OFFSET      = 8'h9b;
  localparam logic [4:0] FRAME_LAST_SHORT = 5'h17;
  localparam logic [4:0] FRAME_LAST_LONG  = 5'h1f;

  typedef enum logic [1:0] {ST_CMD, ST_COUNT, ST_WDATA, ST_RDREG} acd_state_e;
endpackage : acd_pkg
`default_nettype wire

/* File: acd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module acd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import acd_pkg::*;

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // The first stage feeds only the second, so a metastable level never spreads.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : acd_sync
`default_nettype wire

/* File: acd_top.sv */
// How it works
// - A new result drives result_ready_n low and clears the ready status bit.
// - After read-result the result shifts out on rising edges, MSB first.
// - Gate mode: ready rises on first falling edge of a read; pulse mode waits.
// - Result frame is three or four bytes MSB first; more clocks repeat it.
// - Without continuous readout serial output does not mirror ready while idle.
// - Input sampled on falling serial clock edges, output updated on rising edges.
// - Exit-sleep, enter-sleep and reset decode on the upper seven bits.
// - Start, stop and read-result decode on the upper seven bits.
// - Continuous on, continuous off and both calibrations need exact eight bits.
// - Don't-care opcodes use seven bits; register read/write use the upper four; all others use all eight.
// - Register read: opcode byte with the address in its low four bits, then count-minus-one byte.
// - Register read data MSB appears on the seventeenth rising edge.
// - Register write: opcode byte with the address in its low four bits, count-minus-one byte, then data bytes MSB first.
// - Continuous readout is default; only the cancel opcode is accepted in it.
// - Reset opcode restarts the filter and restores all register defaults.
// - Start converts once in pulse mode, else repeatedly until stop.
// - Stop lets the running conversion finish; when stopped it changes nothing.
// - Checksum is the low byte of the three result bytes plus 9bh.
// - With flag and checksum on, checksum bit 7 carries the range flag.
// - With flag on and checksum off, the range flag replaces result bit 0.
// - Single-shot select clear means gate mode, set means pulse mode.
`timescale 1ns/1ps
`default_nettype none
module acd_top #(
  parameter logic [1:0] ID_BITS = 2'h0  // Arbitrary identification value.
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [acd_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       cs_n,
  input  wire logic                       sclk,
  input  wire logic                       din,
  output logic                            dout,
  output logic                            result_ready_n,
  input  wire logic                       conv_done,
  input  wire logic [23:0]                conv_result,
  input  wire logic                       conv_out_of_range,
  output logic                            conv_run,
  output logic                            conv_start,
  output logic                            filter_restart,
  output logic                            sleep_mode,
  output logic                            offset_cal_go,
  output logic                            gain_cal_go
);
  import acd_pkg::*;

  logic [2:0]  pin_s;
  logic        cs_s;
  logic        sclk_s;
  logic        din_s;
  logic        sclk_d_ff;
  logic        rise;
  logic        fall;
  logic [2:0]  bitcnt_ff;
  logic [7:0]  rxsh_ff;
  logic [7:0]  rx_byte;
  logic        byte_done;
  acd_state_e  state_ff;
  logic [3:0]  addr_ff;
  logic [3:0]  cnt_ff;
  logic        is_read_ff;
  logic [7:0]  cfg_ff [0:NREG-1];
  logic        cont_ff;
  logic        run_ff;
  logic        single_ff;
  logic        stop_pend_ff;
  logic        start_ff;
  logic        ready_n_ff;
  logic [23:0] result_ff;
  logic        oor_ff;
  logic        shift_ff;
  logic [4:0]  idx_ff;
  logic        dout_ff;
  logic        sleep_ff;
  logic        frst_ff;
  logic        ofs_ff;
  logic        gan_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;

  acd_sync #(.W(3)) u_sync (
    .clk  (ref_clk),
    .rstn (rstn),
    .d    ({cs_n, sclk, din}),
    .q    (pin_s)
  );
  assign cs_s   = pin_s[2];
  assign sclk_s = pin_s[1];
  assign din_s  = pin_s[0];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end
  assign rise = sclk_s & ~sclk_d_ff & ~cs_s;
  assign fall = ~sclk_s & sclk_d_ff & ~cs_s;

  // Receive shifter: input bits are taken on falling edges only.
  always_ff @(posedge ref_clk) begin
    if (!rstn || cs_s) begin
      bitcnt_ff <= 3'h0;
      rxsh_ff   <= 8'h00;
    end else if (fall) begin
      rxsh_ff   <= rx_byte;
      bitcnt_ff <= bitcnt_ff + 3'h1;
    end
  end
  assign rx_byte   = {rxsh_ff[6:0], din_s};
  assign byte_done = fall && (bitcnt_ff == 3'h7);

  // Opcode decode. In continuous readout only the cancel opcode gets through.
  logic at_cmd;
  logic cmd_ok;
  logic d_wake, d_sleep, d_reset, d_start, d_stop, d_rdata;
  logic d_cont, d_cancel, d_ofs, d_gan, d_register_read_cmd, d_register_write_cmd, d_unknown;
  assign at_cmd   = byte_done && (state_ff == ST_CMD);
  assign cmd_ok   = at_cmd && !cont_ff;
  assign d_wake   = cmd_ok && (rx_byte[7:1] == OP7_WAKE);
  assign d_sleep  = cmd_ok && (rx_byte[7:1] == OP7_SLEEP);
  assign d_reset  = cmd_ok && (rx_byte[7:1] == OP7_RESET);
  assign d_start  = cmd_ok && (rx_byte[7:1] == OP7_START);
  assign d_stop   = cmd_ok && (rx_byte[7:1] == OP7_STOP);
  assign d_rdata  = cmd_ok && (rx_byte[7:1] == OP7_RDATA);
  assign d_cont   = cmd_ok && (rx_byte == OP_CONT);
  assign d_cancel = at_cmd && (rx_byte == OP_CANCEL);
  assign d_ofs    = cmd_ok && (rx_byte == OP_ZERO_OFFSET_CAL_CMD);
  assign d_gan    = cmd_ok && (rx_byte == OP_FULL_SCALE_CAL_CMD);
  assign d_register_read_cmd   = cmd_ok && (rx_byte[7:4] == OP_REGISTER_READ_CMD_HI);
  assign d_register_write_cmd   = cmd_ok && (rx_byte[7:4] == OP_REGISTER_WRITE_CMD_HI);
  assign d_unknown = cmd_ok && !(d_wake || d_sleep || d_reset || d_start || d_stop ||
                     d_rdata || d_cont || d_cancel || d_ofs || d_gan || d_register_read_cmd || d_register_write_cmd);

  // Multi-byte framing; raising chip select abandons any command part-way.
  always_ff @(posedge ref_clk) begin
    if (!rstn || cs_s) begin
      state_ff   <= ST_CMD;
      addr_ff    <= 4'h0;
      cnt_ff     <= 4'h0;
      is_read_ff <= 1'b0;
    end else if (byte_done) begin
      case (state_ff)
        ST_CMD: begin
          if (d_register_read_cmd || d_register_write_cmd) begin
            state_ff   <= ST_COUNT;
            addr_ff    <= rx_byte[3:0];
            is_read_ff <= d_register_read_cmd;
          end
        end
        ST_COUNT: begin
          cnt_ff   <= rx_byte[3:0];
          state_ff <= is_read_ff ? ST_RDREG : ST_WDATA;
        end
        ST_WDATA, ST_RDREG: begin
          addr_ff <= addr_ff + 4'h1;
          cnt_ff  <= cnt_ff - 4'h1;
          if (cnt_ff == 4'h0) begin
            state_ff <= ST_CMD;
          end
        end
        default: state_ff <= ST_CMD;
      endcase
    end
  end

  // Register view: identification bits and the ready flag are live, not stored.
  function automatic logic [7:0] reg_view(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == CFG0_IDX) begin
      v = cfg_ff[0] | {2'b00, ID_BITS, 4'h0};
    end else if (a == CFG2_IDX) begin
      v = {ready_n_ff, cfg_ff[2][6:0]};
    end else if (a <= REG_LAST) begin
      v = cfg_ff[a];
    end
    return v;
  endfunction : reg_view

  logic        ser_wr;
  logic        apb_acc;
  logic [9:0]  apb_idx;
  logic        apb_reg_hit;
  logic        apb_stat_hit;
  logic        apb_wr;
  logic [7:0]  rd_byte;
  logic [7:0]  apb_byte;
  logic [7:0]  cfg2_view;
  logic [31:0] apb_rdata;
  assign ser_wr       = byte_done && (state_ff == ST_WDATA) && (addr_ff <= REG_LAST);
  assign apb_acc      = psel && penable;
  assign apb_idx      = paddr[APB_AW-1:2];
  assign apb_reg_hit  = (paddr[1:0] == 2'b00) && (apb_idx <= {6'h00, REG_LAST});
  assign apb_stat_hit = (paddr[1:0] == 2'b00) && (apb_idx == APB_STATUS_IDX);
  assign apb_wr       = apb_acc && pready_ff && pwrite && apb_reg_hit;
  assign rd_byte      = reg_view(addr_ff);
  assign apb_byte     = reg_view(apb_idx[3:0]);
  assign cfg2_view    = reg_view(CFG2_IDX);

  always_comb begin
    apb_rdata = 32'h0000_0000;
    if (apb_reg_hit) begin
      apb_rdata = {24'h00_0000, apb_byte};
    end else if (apb_stat_hit) begin
      apb_rdata[STAT_READY_BIT] = ready_n_ff;
      apb_rdata[STAT_CONT_BIT]  = cont_ff;
      apb_rdata[STAT_RUN_BIT]   = run_ff;
      apb_rdata[STAT_SLEEP_BIT] = sleep_ff;
    end
  end

  // Serial writes win over a bus write in the same cycle; read-only bits are masked.
  always_ff @(posedge ref_clk) begin
    if (!rstn || d_reset) begin
      for (int i = 0; i < NREG; i++) begin
        cfg_ff[i] <= REG_RST[i];
      end
    end else if (ser_wr) begin
      cfg_ff[addr_ff] <= (cfg_ff[addr_ff] & ~REG_WMASK[addr_ff]) |
                         (rx_byte & REG_WMASK[addr_ff]);
    end else if (apb_wr) begin
      cfg_ff[apb_idx[3:0]] <= (cfg_ff[apb_idx[3:0]] & ~REG_WMASK[apb_idx[3:0]]) |
                              (pwdata[7:0] & REG_WMASK[apb_idx[3:0]]);
    end
  end

  // The bus answers one cycle into the access phase; a write lands on the closing edge.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (apb_acc && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !(apb_reg_hit || (apb_stat_hit && !pwrite));
      prdata_ff  <= apb_rdata;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  logic pulse_mode;
  logic flag_en;
  logic sum_en;
  assign pulse_mode = cfg_ff[2][CFG2_PULSE_BIT];
  assign flag_en    = cfg_ff[1][CFG1_FLAG_BIT];
  assign sum_en     = cfg_ff[1][CFG1_SUM_BIT];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cont_ff <= 1'b1;
    end else if (d_cont) begin
      cont_ff <= 1'b1;
    end else if (d_cancel) begin
      cont_ff <= 1'b0;
    end
  end

  // A stop only arms a flag, so the conversion under way is never cut short.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      run_ff       <= 1'b0;
      single_ff    <= 1'b0;
      stop_pend_ff <= 1'b0;
      start_ff     <= 1'b0;
    end else begin
      start_ff <= d_start;
      if (d_start) begin
        run_ff       <= 1'b1;
        single_ff    <= pulse_mode;
        stop_pend_ff <= 1'b0;
      end else if (d_stop && run_ff) begin
        stop_pend_ff <= 1'b1;
      end else if (conv_done && (single_ff || stop_pend_ff)) begin
        run_ff       <= 1'b0;
        stop_pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ready_n_ff <= 1'b1;
      result_ff  <= 24'h00_0000;
      oor_ff     <= 1'b0;
    end else if (conv_done) begin
      ready_n_ff <= 1'b0;
      result_ff  <= conv_result;
      oor_ff     <= conv_out_of_range;
    end else if (d_reset) begin
      ready_n_ff <= 1'b1;
    end else if (pulse_mode ? start_ff : (shift_ff && fall)) begin
      ready_n_ff <= 1'b1;
    end
  end

  // Result frame, left aligned: the short frame uses the top 24 bits only.
  logic [7:0]  sum_w;
  logic [7:0]  low_w;
  logic [31:0] frame_w;
  logic [4:0]  last_idx;
  assign sum_w    = result_ff[23:16] + result_ff[15:8] + result_ff[7:0] + SUM_OFFSET;
  assign low_w    = (flag_en && !sum_en) ? {result_ff[7:1], oor_ff} : result_ff[7:0];
  assign frame_w  = {result_ff[23:8], low_w,
                     (flag_en ? oor_ff : sum_w[7]), sum_w[6:0]};
  assign last_idx = sum_en ? FRAME_LAST_LONG : FRAME_LAST_SHORT;

  // Output shifter. Only continuous readout lets the pin follow ready while idle.
  always_ff @(posedge ref_clk) begin
    if (!rstn || cs_s) begin
      shift_ff <= 1'b0;
      idx_ff   <= 5'h00;
      dout_ff  <= 1'b0;
    end else if (d_rdata) begin
      shift_ff <= 1'b1;
      idx_ff   <= 5'h00;
    // Filler bytes clocked in during a readout decode as nothing, so the frame keeps going.
    end else if (at_cmd && !d_unknown && (!cont_ff || d_cancel)) begin
      shift_ff <= 1'b0;
    end else if (cont_ff && conv_done) begin
      shift_ff <= 1'b0;
    end else if (rise) begin
      if (shift_ff) begin
        dout_ff <= frame_w[5'h1f - idx_ff];
        idx_ff  <= (idx_ff == last_idx) ? 5'h00 : idx_ff + 5'h01;
      end else if (cont_ff && !ready_n_ff) begin
        dout_ff  <= frame_w[31];
        idx_ff   <= 5'h01;
        shift_ff <= 1'b1;
      end else if (state_ff == ST_RDREG) begin
        dout_ff <= rd_byte[3'h7 - bitcnt_ff];
      end else begin
        dout_ff <= cont_ff & ready_n_ff;
      end
    end else if (!shift_ff && state_ff != ST_RDREG) begin
      dout_ff <= cont_ff & ready_n_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sleep_ff <= 1'b0;
      frst_ff  <= 1'b0;
      ofs_ff   <= 1'b0;
      gan_ff   <= 1'b0;
    end else begin
      frst_ff <= d_reset;
      ofs_ff  <= d_ofs;
      gan_ff  <= d_gan;
      if (d_sleep) begin
        sleep_ff <= 1'b1;
      end else if (d_wake) begin
        sleep_ff <= 1'b0;
      end
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign dout           = dout_ff;
  assign result_ready_n = ready_n_ff;
  assign conv_run       = run_ff;
  assign conv_start     = start_ff;
  assign filter_restart = frst_ff;
  assign sleep_mode     = sleep_ff;
  assign offset_cal_go  = ofs_ff;
  assign gain_cal_go    = gan_ff;

  ready_low_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      conv_done |=> !result_ready_n && !cfg2_view[7])
    else $error("ready not asserted after a new result");
  gate_rise_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      !pulse_mode && shift_ff && fall && !conv_done && !d_reset |=> result_ready_n)
    else $error("gate mode ready did not return high");
  msb_first_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      shift_ff && rise && idx_ff == 5'h00 && !cs_s && !(cont_ff && conv_done)
      |=> dout == $past(frame_w[31]))
    else $error("result MSB not shifted first");
  frame_wrap_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      shift_ff && rise && idx_ff == last_idx && !(cont_ff && conv_done) |=> idx_ff == 5'h00)
    else $error("result frame did not repeat");
  no_mirror_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      (!cont_ff && !shift_ff && state_ff == ST_CMD) [*2] |-> !dout)
    else $error("serial output follows ready outside continuous readout");
  register_read_cmd_msb_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      state_ff == ST_RDREG && rise && bitcnt_ff == 3'h0 |=> dout == $past(rd_byte[7]))
    else $error("register read MSB misplaced");
  cont_cancel_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      cont_ff && at_cmd && rx_byte != OP_CANCEL && rx_byte != OP_CONT && !conv_done
      |=> cont_ff && $stable(run_ff) && $stable(sleep_ff) && state_ff == ST_CMD)
    else $error("opcode accepted during continuous readout");
  reg_reset_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      d_reset |=> cfg_ff[1] == REG_RST[1] && cfg_ff[8] == REG_RST[8] ##1 !filter_restart)
    else $error("reset opcode did not restore defaults");
  start_run_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      d_start |=> conv_run && conv_start ##1 !conv_start)
    else $error("start opcode did not start conversions");
  stop_idle_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      d_stop && !run_ff && !conv_done |=> !conv_run && !stop_pend_ff)
    else $error("stop opcode changed an idle converter");
  ignore_bad_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      d_unknown && !conv_done |=> $stable(run_ff) && $stable(sleep_ff) && $stable(cont_ff))
    else $error("undefined opcode changed state");
endmodule : acd_top
`default_nettype wire

/* File: adc_serial_command_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_decoder_test;
  import acd_pkg::*;
  logic              ref_clk;
  logic              rstn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cs_n;
  logic              sclk;
  logic              din;
  logic              dout;
  logic              result_ready_n;
  logic              done;
  logic [23:0]       res;
  logic              oor;
  logic              cal0;
  logic              cal1;
  logic              crun;
  logic              cstart;
  logic              frst;
  logic              slp;
  logic              rx_stb;
  logic [7:0]        rx_byte;
  logic [16:0]       lfsr;
  logic [8:0]        exp_q[$];
  int                fail_count;
  int                total_checks;
  int                pulses;
  int                starts;
  int                restarts;

  acd_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .result_ready_n(result_ready_n), .conv_done(done), .conv_result(res),
    .conv_out_of_range(oor), .conv_run(crun), .conv_start(cstart), .filter_restart(frst),
    .sleep_mode(slp), .offset_cal_go(cal0), .gain_cal_go(cal1));
  acd_host_model host_u (.ref_clk(ref_clk), .dout(dout), .cs_n(cs_n), .sclk(sclk),
    .din(din), .rx_stb(rx_stb), .rx_byte(rx_byte));

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction : rnd

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic stat(input logic [8:0] e);
    exp_q.push_back(e);
    apb(1'b0, 12'h024, 8'h00);
  endtask : stat

  task automatic rd(input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    host_u.xfer(8'h00, 1'b1);
  endtask : rd

  task automatic op(input logic [7:0] o);
    host_u.xfer(o, 1'b0);
    host_u.stop_frame();
  endtask : op

  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) begin
      check("apb", {pslverr, pslverr ? 8'h00 : prdata[7:0]},
            exp_q.size() ? exp_q.pop_front() : 9'h1ff);
    end
    if (rx_stb) begin
      check("dout", {1'b0, rx_byte}, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
    end
    if (cal0 || cal1) begin
      pulses <= pulses + 1;
    end
    if (cstart) begin
      starts <= starts + 1;
    end
    if (frst) begin
      restarts <= restarts + 1;
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end

  initial begin
    logic [7:0] op_t [7];
    logic [7:0] st_t [7];
    logic [7:0] cfg_t [4];
    logic [23:0] r;
    logic [7:0] ck;
    logic [7:0] w0;
    logic [7:0] w1;
    logic f;
    op_t = '{8'h09, 8'h05, 8'h03, 8'h1a, 8'h10, 8'h11, 8'h0b};
    st_t = '{8'h05, 8'h0d, 8'h05, 8'h05, 8'h07, 8'h05, 8'h05};
    cfg_t = '{8'h08, 8'h48, 8'hc8, 8'h88};
    lfsr = 17'd98496;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    done = 1'b0;
    res = '0;
    oor = 1'b0;
    pulses = 0;
    starts = 0;
    restarts = 0;
    // Reset is synchronous everywhere, so two edges clear the synchroniser as well.
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    stat(9'h003);
    exp_q.push_back({1'b0, REG_RST[1]});
    apb(1'b0, 12'h004, 8'h00);
    stat(9'h003);
    exp_q.push_back(9'h100);
    apb(1'b0, 12'h028, 8'h00);
    $display("test reset done");
    op(8'h09);
    op(8'h11);
    stat(9'h001);
    for (int i = 0; i < 7; i++) begin
      op(op_t[i]);
      stat({1'b0, st_t[i]});
      check("run", {7'h00, slp, crun}, {7'h00, st_t[i][3:2]});
    end
    $display("test opcodes done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h004, cfg_t[k]);
      r = {rnd(), rnd(), rnd()};
      f = lfsr[3];
      // No result update lands during a read, so every read is clean.
      done <= 1'b1;
      res <= r;
      oor <= f;
      @(posedge ref_clk);
      done <= 1'b0;
      repeat (8) @(posedge ref_clk);
      check("ready", {8'h00, result_ready_n}, 9'h000);
      if (k == 0) begin
        stat(9'h000);
      end
      ck = r[23:16] + r[15:8] + r[7:0] + SUM_OFFSET;
      if (cfg_t[k][7] && cfg_t[k][6]) begin
        ck[7] = f;
      end
      if (cfg_t[k][7] && !cfg_t[k][6]) begin
        r[0] = f;
      end
      host_u.xfer({7'h09, k[0]}, 1'b0);
      rd(r[23:16]);
      rd(r[15:8]);
      rd(r[7:0]);
      if (cfg_t[k][6]) begin
        rd(ck);
      end
      rd(r[23:16]);
      host_u.stop_frame();
      check("ready", {8'h00, result_ready_n}, 9'h001);
    end
    apb(1'b1, 12'h008, 8'h10);
    done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
    host_u.xfer(8'h12, 1'b0);
    rd(r[23:16]);
    host_u.stop_frame();
    check("pulse", {8'h00, result_ready_n}, 9'h000);
    op(8'h08);
    check("pulse", {8'h00, result_ready_n}, 9'h001);
    $display("test readout done");
    w0 = rnd();
    w1 = rnd();
    host_u.xfer(8'h43, 1'b0);
    host_u.xfer(8'h01, 1'b0);
    host_u.xfer(w0, 1'b0);
    host_u.xfer(w1, 1'b0);
    host_u.stop_frame();
    host_u.xfer(8'h23, 1'b0);
    host_u.xfer(8'h01, 1'b0);
    rd(w0);
    rd(w1);
    host_u.stop_frame();
    exp_q.push_back({1'b0, w1});
    apb(1'b0, 12'h010, 8'h00);
    $display("test registers done");
    op(8'h06);
    exp_q.push_back({1'b0, REG_RST[1]});
    apb(1'b0, 12'h004, 8'h00);
    $display("test reset opcode done");
    // Inputs are taken as settled before each calibration opcode.
    op(8'h18);
    op(8'h19);
    op(8'h1b);
    check("cal", 9'(pulses), 9'h002);
    check("start", 9'(starts), 9'h002);
    check("restart", 9'(restarts), 9'h001);
    $display("test calibration done");
    repeat (4) @(posedge ref_clk);
    check("queue", 9'(exp_q.size()), 9'h000);
    close_out();
  end
endmodule : adc_serial_command_decoder_test
`default_nettype wire
